// File: rtl/sfrc_pkg.sv
// Purpose: Shared constants and carriers for the synthesizer function and resync control block
// Assumes: 32-bit serial words, control bits in the three low bits
// Notes:   All field positions and timing counts are named here once
package sfrc_pkg;
  // Register select codes in the three control bits
  localparam logic [2:0] SEL_INT_FRACTION = 3'h0;
  localparam logic [2:0] SEL_PHASE     = 3'h1;
  localparam logic [2:0] SEL_MOD_REF   = 3'h2;
  localparam logic [2:0] SEL_FUNCTION  = 3'h3;
  localparam logic [2:0] SEL_RESYNC    = 3'h4;
  // Function register bit positions
  localparam int FN_CNT_RESET_BIT  = 3;
  localparam int FN_CP_TRISTATE_BIT = 4;
  localparam int FN_POWER_DOWN_BIT = 5;
  localparam int FN_POLARITY_BIT   = 6;
  localparam int FN_LOCK_WIN_BIT   = 7;
  localparam int FN_RESEED_DIS_BIT = 14;
  // Modulus/reference register fields
  localparam int MR_SLIP_EN_BIT    = 28;
  localparam int MR_MOD_LSB        = 3;
  // Resync timer register fields
  localparam int RT_COUNT_LSB      = 7;
  localparam int RT_MODE_LSB       = 19;
  localparam logic [1:0] RT_MODE_RESYNC = 2'h2;
  // Field widths
  localparam int FIELD_W           = 12;
  localparam int WORD_W            = 32;
  // Reset values
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Lock detector timing
  localparam int LOCK_COUNT        = 40;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int WIN_WIDE_NS       = 10;
  localparam int WIN_NARROW_NS     = 6;
  // Longest error allowed, rounded down, at least one cycle
  localparam int WIN_WIDE_CYC      = (WIN_WIDE_NS / CLK_PERIOD_NS) < 1 ? 1 : (WIN_WIDE_NS / CLK_PERIOD_NS);
  localparam int WIN_NARROW_CYC    = (WIN_NARROW_NS / CLK_PERIOD_NS) < 1 ? 1 : (WIN_NARROW_NS / CLK_PERIOD_NS);
  // Maximum extra charge pump cells
  localparam int MAX_CELLS         = 7;

  // Decoded function settings
  typedef struct packed {
    logic reseed_disable;
    logic lock_window_select;
    logic polarity;
    logic power_down;
    logic cp_tristate;
    logic counter_reset;
  } sfrc_func_s;

  // Slip cell controller states
  typedef enum logic [1:0] {
    SFRC_IDLE  = 2'b00,
    SFRC_RAMP  = 2'b01,
    SFRC_DRAIN = 2'b10
  } sfrc_slip_e;
endpackage

// File: rtl/sfrc_top.sv
// What this block does
// [RQ1] Function bit 4 three-states the charge pump
// [RQ2] Function bit 5 enters or leaves power-down
// [RQ3] Power-down keeps every programmed register value
// [RQ4] Power-down loads counters, tristates, resets lock, debiases
// [RQ5] Shift register keeps accepting words while down
// [RQ6] Host sets polarity bit to match VCO
// [RQ7] Window select 0: 40 cycles within 10 ns
// [RQ8] Window select 1: 40 cycles within 6 ns; code rounds this up to one 10 ns cycle, same as select 0
// [RQ9] Bit 14 low: reseed modulator on word 0
// [RQ10] Control bits 1,0,0 load resync timer register
// [RQ11] 12-bit count sets resync event spacing
// [RQ12] Host sets mode 1,0 for resync, else 0
// [RQ13] Host writes zero into reserved bits
// [RQ14] Host programs registers in documented power-up order
// [RQ15] Host keeps comparison rate at most 32 MHz
// [RQ16] Divide-by-two stage gives 50% comparison clock
// [RQ17] Fractional modulus accepted over full 12 bits
// [RQ18] Each imminent slip adds one extra cell
// [RQ19] Never more than seven extra cells
// [RQ20] After overshoot, remove cells one by one
// [RQ21] Modulus/reference bit 28 enables slip reduction
// [RQ22] Control bits 0,1,1 load function register
// [RQ23] Function bit 3 holds counters in reset
// [RQ24] Shift on serial clock rise, transfer on strobe
// [RQ25] Out-of-window cycle restarts count, drops lock
// [RQ26] Cells cleared when disabled or powered down
// Purpose: Serial register capture, function decode, lock detect, resync timer, slip cells
// Assumes: Serial pins and comparator events are synchronous to i_clk
// Notes:   Function, resync and modulus/reference registers drive logic; words for the other select codes are not stored
`timescale 1ns/1ps
module sfrc_top #(
  parameter int WORD_W = sfrc_pkg::WORD_W,
  parameter int CELLS  = sfrc_pkg::MAX_CELLS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_sclk,          // Serial clock pin
  input  wire logic        i_sdata,         // Serial data pin
  input  wire logic        i_transfer_strobe, // Latch strobe pin
  input  wire logic        i_cmp_event,     // One pulse per comparison cycle
  input  wire logic [7:0]  i_phase_err_cyc, // Phase error width of that cycle, in clocks
  input  wire logic        i_ref_div2_en,   // Reference divide-by-two enabled
  input  wire logic        i_div_ref_pulse, // Pulse per divided reference period
  input  wire logic        i_slip_imminent, // Slip detector pulse
  input  wire logic        i_overshoot,     // VCO passed target
  output logic             o_cp_tristate,
  output logic             o_power_down,
  output logic             o_counter_load,
  output logic             o_rf_debias,
  output logic             o_polarity,
  output logic             o_lock,
  output logic             o_mod_reseed,
  output logic             o_sync_pulse,
  output logic             o_cmp_clk,
  output logic [2:0]       o_extra_cells,
  output logic [11:0]      o_fractional_modulus
);

  // Serial shift register and its edge tracking
  logic [WORD_W-1:0] shift_r;
  logic              sclk_d_r;              // Previous serial clock level
  logic              strobe_d_r;            // Previous strobe level
  // Captured register images; contents survive power-down
  logic [WORD_W-1:0] func_r;
  logic [WORD_W-1:0] resync_r;
  logic [WORD_W-1:0] modref_r;
  logic              sclk_rise;
  logic              strobe_rise;
  sfrc_pkg::sfrc_func_s fn;

  assign sclk_rise   = i_sclk & ~sclk_d_r;
  assign strobe_rise = i_transfer_strobe & ~strobe_d_r;

  // Decode the function word into named controls
  always_comb begin
    fn.counter_reset      = func_r[sfrc_pkg::FN_CNT_RESET_BIT];
    fn.cp_tristate        = func_r[sfrc_pkg::FN_CP_TRISTATE_BIT];
    fn.power_down         = func_r[sfrc_pkg::FN_POWER_DOWN_BIT];
    fn.polarity           = func_r[sfrc_pkg::FN_POLARITY_BIT];
    fn.lock_window_select = func_r[sfrc_pkg::FN_LOCK_WIN_BIT];
    fn.reseed_disable     = func_r[sfrc_pkg::FN_RESEED_DIS_BIT];
  end

  // Edge history of the serial pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_d_r   <= 1'b0;
      strobe_d_r <= 1'b0;
    end else begin
      sclk_d_r   <= i_sclk;
      strobe_d_r <= i_transfer_strobe;
    end
  end

  // Shift in on each serial clock rise; never gated by power-down
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_r <= sfrc_pkg::REG_RESET;
    end else if (sclk_rise) begin // RQ24 RQ5
      shift_r <= {shift_r[WORD_W-2:0], i_sdata};
    end
  end

  // Transfer to the addressed register on strobe rise
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      func_r   <= sfrc_pkg::REG_RESET;
      resync_r <= sfrc_pkg::REG_RESET;
      modref_r <= sfrc_pkg::REG_RESET;
    end else if (strobe_rise) begin // RQ24 RQ5 RQ3
      case (shift_r[2:0])
        sfrc_pkg::SEL_FUNCTION: begin
          func_r <= shift_r; // RQ22
        end
        sfrc_pkg::SEL_RESYNC: begin
          resync_r <= shift_r; // RQ10
        end
        sfrc_pkg::SEL_MOD_REF: begin
          modref_r <= shift_r; // RQ21
        end
        default: begin
          // Other registers live outside this block
        end
      endcase
    end
  end

  // Full 12-bit modulus as programmed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fractional_modulus <= 12'h000;
    end else begin
      o_fractional_modulus <= modref_r[sfrc_pkg::MR_MOD_LSB +: sfrc_pkg::FIELD_W]; // RQ17
    end
  end

  // Power-down and charge pump controls
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_power_down   <= 1'b0;
      o_cp_tristate  <= 1'b0;
      o_counter_load <= 1'b0;
      o_rf_debias    <= 1'b0;
      o_polarity     <= 1'b0;
    end else begin
      o_power_down   <= fn.power_down; // RQ2
      o_cp_tristate  <= fn.cp_tristate | fn.power_down; // RQ1 RQ4
      o_counter_load <= fn.counter_reset | fn.power_down; // RQ23 RQ4
      o_rf_debias    <= fn.power_down; // RQ4
      o_polarity     <= fn.polarity;
    end
  end

  // Reseed pulse on each word to register 0 unless disabled
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mod_reseed <= 1'b0;
    end else begin
      o_mod_reseed <= strobe_rise && (shift_r[2:0] == sfrc_pkg::SEL_INT_FRACTION) && !fn.reseed_disable; // RQ9
    end
  end

  // Lock detector: count consecutive in-window comparison cycles
  logic [5:0] lock_cnt_r;
  logic [7:0] win_cyc;
  logic       in_win;
  assign win_cyc = fn.lock_window_select ? 8'(sfrc_pkg::WIN_NARROW_CYC) : 8'(sfrc_pkg::WIN_WIDE_CYC);
  assign in_win  = (i_phase_err_cyc <= win_cyc); // RQ7 RQ8

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_cnt_r <= 6'h00;
      o_lock     <= 1'b0;
    end else if (fn.power_down) begin // RQ4
      lock_cnt_r <= 6'h00;
      o_lock     <= 1'b0;
    end else if (i_cmp_event) begin
      if (!in_win) begin // RQ25
        lock_cnt_r <= 6'h00;
        o_lock     <= 1'b0;
      end else if (lock_cnt_r == 6'(sfrc_pkg::LOCK_COUNT - 1)) begin // RQ7 RQ8
        o_lock <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 6'h01;
      end
    end
  end

  // Resync timer: sync event every count x modulus comparison cycles
  logic [11:0] rt_div_r;
  logic [11:0] rt_mod_r;
  logic        rt_active;
  assign rt_active = (resync_r[sfrc_pkg::RT_MODE_LSB +: 2] == sfrc_pkg::RT_MODE_RESYNC) && !fn.power_down;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rt_div_r     <= 12'h000;
      rt_mod_r     <= 12'h000;
      o_sync_pulse <= 1'b0;
    end else begin
      o_sync_pulse <= 1'b0;
      if (!rt_active || strobe_rise) begin
        rt_div_r <= 12'h000;
        rt_mod_r <= 12'h000;
      end else if (i_cmp_event) begin
        if (rt_mod_r + 12'h001 >= o_fractional_modulus) begin
          rt_mod_r <= 12'h000;
          if (rt_div_r + 12'h001 >= resync_r[sfrc_pkg::RT_COUNT_LSB +: sfrc_pkg::FIELD_W]) begin // RQ11
            rt_div_r     <= 12'h000;
            o_sync_pulse <= 1'b1;
          end else begin
            rt_div_r <= rt_div_r + 12'h001;
          end
        end else begin
          rt_mod_r <= rt_mod_r + 12'h001;
        end
      end
    end
  end

  // Divide-by-two comparison clock, toggles per divided period
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmp_clk <= 1'b0;
    end else if (!i_ref_div2_en) begin
      o_cmp_clk <= i_div_ref_pulse;
    end else if (i_div_ref_pulse) begin
      o_cmp_clk <= ~o_cmp_clk; // RQ16
    end
  end

  // Slip reduction cell counter
  sfrc_pkg::sfrc_slip_e slip_st_r;
  logic slip_en;
  assign slip_en = modref_r[sfrc_pkg::MR_SLIP_EN_BIT] && !fn.power_down; // RQ21

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      slip_st_r     <= sfrc_pkg::SFRC_IDLE;
      o_extra_cells <= 3'h0;
    end else if (!slip_en) begin // RQ26
      slip_st_r     <= sfrc_pkg::SFRC_IDLE;
      o_extra_cells <= 3'h0;
    end else begin
      case (slip_st_r)
        sfrc_pkg::SFRC_IDLE, sfrc_pkg::SFRC_RAMP: begin
          if (i_overshoot && o_extra_cells != 3'h0) begin // RQ20
            slip_st_r <= sfrc_pkg::SFRC_DRAIN;
          end else if (i_slip_imminent && o_extra_cells != 3'(CELLS)) begin // RQ18 RQ19
            slip_st_r     <= sfrc_pkg::SFRC_RAMP;
            o_extra_cells <= o_extra_cells + 3'h1;
          end
        end
        sfrc_pkg::SFRC_DRAIN: begin
          if (o_extra_cells == 3'h0) begin
            slip_st_r <= sfrc_pkg::SFRC_IDLE;
          end else begin
            o_extra_cells <= o_extra_cells - 3'h1; // RQ20
          end
        end
        default: begin
          slip_st_r <= sfrc_pkg::SFRC_IDLE;
        end
      endcase
    end
  end

  // Checks beside the logic
  chk_tristate_follow: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ1
    (fn.cp_tristate || fn.power_down) |=> o_cp_tristate) else $error("charge pump not three-stated");
  chk_pd_effects: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ4
    $rose(o_power_down) |-> (o_counter_load && o_rf_debias && o_cp_tristate && !o_lock))
    else $error("power-down effects missing");
  chk_func_latch: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ22
    (strobe_rise && shift_r[2:0] == 3'h3) |=> (func_r == $past(shift_r))) else $error("function word not latched");
  chk_resync_latch: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ10
    (strobe_rise && shift_r[2:0] == 3'h4) |=> (resync_r == $past(shift_r))) else $error("resync word not latched");
  chk_lock_count: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ7
    $rose(o_lock) |-> (lock_cnt_r == 6'd39)) else $error("lock set at wrong count");
  chk_lock_drop: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ25
    (i_cmp_event && !in_win) |=> (!o_lock && lock_cnt_r == 6'h00)) else $error("lock kept after bad cycle");
  // Saturation: a full ramp must hold at seven, never wrap to zero
  chk_cells_max: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ19
    (slip_en && o_extra_cells == 3'h7 && slip_st_r != sfrc_pkg::SFRC_DRAIN) |=> (o_extra_cells == 3'h7))
    else $error("extra cells went past seven");
  chk_cells_clear: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ26
    !slip_en |=> (o_extra_cells == 3'h0)) else $error("cells not cleared");
  chk_reseed_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ9
    (strobe_rise && shift_r[2:0] == 3'h0 && fn.reseed_disable) |=> !o_mod_reseed)
    else $error("reseed despite disable");
  chk_shift_pd: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ5
    (sclk_rise && fn.power_down) |=> (shift_r[0] == $past(i_sdata))) else $error("shift stalled in power-down");

endmodule // sfrc_top

// File: sim/sfrc_host_model.sv
// Purpose: Host controller model writing 32-bit words over the three-wire port
// Assumes: Pins change on falling edges of the block clock
// Notes:   Serial clock rests low between words; data line shows inverse of last bit
`timescale 1ns/1ps
module sfrc_host_model (
  input  wire logic i_clk,    // Block clock
  output logic      o_sclk,   // Serial clock, idle low
  output logic      o_sdata,  // Serial data
  output logic      o_strobe  // Transfer strobe
);
  // Idle pins at time zero
  initial begin
    o_sclk   = 1'b0;
    o_sdata  = 1'b0;
    o_strobe = 1'b0;
  end

  // Shift MSB first, low phase stretched by slow, then strobe
  task automatic send(input logic [31:0] w, input int slow);
    for (int i = 31; i >= 0; i--) begin
      @(negedge i_clk);
      o_sdata = w[i];
      @(negedge i_clk);
      o_sclk = 1'b1;
      @(negedge i_clk);
      o_sclk = 1'b0;
      repeat (slow) @(negedge i_clk);
    end
    @(negedge i_clk);
    o_strobe = 1'b1;
    @(negedge i_clk);
    o_strobe = 1'b0;
    // Released line must not keep the last bit
    o_sdata = ~o_sdata;
  endtask
endmodule // sfrc_host_model

// File: sim/testbench.sv
// Purpose: Self-checking bench for the function and resync control block
// Assumes: Host model drives the serial pins; bench drives comparator side
// Notes:   Inputs change on falling edges only
`timescale 1ns/1ps
module testbench;
  logic        i_clk = 1'b0;  // 100 MHz clock
  logic        i_rstn = 1'b0; // Active low reset
  logic        sclk, sdata, strobe;
  logic        i_cmp_event = 1'b0, i_ref_div2_en = 1'b0, i_div_ref_pulse = 1'b0;
  logic        i_slip_imminent = 1'b0, i_overshoot = 1'b0;
  logic [7:0]  i_phase_err_cyc = 8'h00;
  logic        o_cp_tristate, o_power_down, o_counter_load, o_rf_debias, o_polarity;
  logic        o_lock, o_mod_reseed, o_sync_pulse, o_cmp_clk;
  logic [2:0]  o_extra_cells;
  logic [11:0] o_fractional_modulus;
  int          err_count = 0, n_tests = 0, ev_n = 0, last_ev = 0, gap = 0;
  int          sync_n = 0, reseed_n = 0, tog_n = 0, s0;
  logic        prev_cmp = 1'b0;
  logic [2:0]  prev_cells;

  always #5 i_clk = ~i_clk;

  sfrc_host_model u_sfrc_host_model (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata), .o_strobe(strobe));
  sfrc_top u_sfrc_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(sclk), .i_sdata(sdata),
    .i_transfer_strobe(strobe), .i_cmp_event(i_cmp_event), .i_phase_err_cyc(i_phase_err_cyc),
    .i_ref_div2_en(i_ref_div2_en), .i_div_ref_pulse(i_div_ref_pulse), .i_slip_imminent(i_slip_imminent),
    .i_overshoot(i_overshoot), .o_cp_tristate(o_cp_tristate), .o_power_down(o_power_down),
    .o_counter_load(o_counter_load), .o_rf_debias(o_rf_debias), .o_polarity(o_polarity), .o_lock(o_lock),
    .o_mod_reseed(o_mod_reseed), .o_sync_pulse(o_sync_pulse), .o_cmp_clk(o_cmp_clk),
    .o_extra_cells(o_extra_cells), .o_fractional_modulus(o_fractional_modulus));

  // Pulse and toggle counters, sampled mid-cycle
  always @(negedge i_clk) begin
    if (o_mod_reseed === 1'b1) reseed_n++;
    if (o_cmp_clk !== prev_cmp) tog_n++;
    prev_cmp = o_cmp_clk;
    if (o_sync_pulse === 1'b1) begin
      gap = ev_n - last_ev;
      last_ev = ev_n;
      sync_n++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Word builders; reserved positions stay zero
  function automatic logic [31:0] fw(input logic [31:0] b);
    return {b[31:3], sfrc_pkg::SEL_FUNCTION};
  endfunction
  function automatic logic [31:0] mr(input logic slip, input logic [11:0] m);
    return {3'h0, slip, 13'h0000, m, sfrc_pkg::SEL_MOD_REF};
  endfunction
  function automatic logic [31:0] rs(input logic [1:0] md, input logic [11:0] c);
    return {11'h000, md, c, 4'h0, sfrc_pkg::SEL_RESYNC};
  endfunction

  task automatic wr(input logic [31:0] w, input int slow = 0);
    u_sfrc_host_model.send(w, slow);
    repeat (4) @(negedge i_clk);
  endtask

  // One comparison event every four clocks, 25 MHz rate
  task automatic events(input int n, input logic [7:0] err);
    repeat (n) begin
      @(negedge i_clk);
      i_cmp_event = 1'b1;
      i_phase_err_cyc = err;
      ev_n++;
      @(negedge i_clk);
      i_cmp_event = 1'b0;
      repeat (2) @(negedge i_clk);
    end
    repeat (3) @(negedge i_clk);
  endtask

  task automatic pulse_in(ref logic s, input int n);
    repeat (n) begin
      @(negedge i_clk);
      s = 1'b1;
      @(negedge i_clk);
      s = 1'b0;
      repeat (2) @(negedge i_clk);
    end
    repeat (3) @(negedge i_clk);
  endtask

  // Lock needs exactly 40 good events; one bad one restarts
  task automatic t_lock(input logic win);
    wr(fw(32'(win) << sfrc_pkg::FN_LOCK_WIN_BIT));
    // Bad event first, so a count left by an earlier run restarts
    events(1, 8'h02);
    check(o_lock, 1'b0);
    events(39, 8'h01);
    check(o_lock, 1'b0);
    events(1, 8'h01);
    check(o_lock, 1'b1);
    events(1, 8'h02);
    check(o_lock, 1'b0);
    events(39, 8'h01);
    check(o_lock, 1'b0);
  endtask

  // Power-down effects, writes accepted meanwhile, values kept
  task automatic t_power;
    wr(fw(32'h0000_0050), 2);
    check(o_cp_tristate, 1'b1);
    wr(fw(32'h0000_0048));
    check({o_counter_load, o_cp_tristate, o_polarity}, 3'h5);
    wr(mr(1'b0, 12'hfff));
    check(o_fractional_modulus, 12'hfff);
    events(40, 8'h01);
    wr(fw(32'h0000_0060));
    check({o_power_down, o_cp_tristate, o_counter_load, o_rf_debias, o_lock}, 5'h1e);
    check(o_fractional_modulus, 12'hfff);
    wr(mr(1'b0, 12'h0a5));
    check(o_fractional_modulus, 12'h0a5);
    wr(fw(32'h0000_0040));
    check({o_power_down, o_cp_tristate, o_rf_debias, o_polarity}, 4'h1);
    check(o_fractional_modulus, 12'h0a5);
  endtask

  // Reseed pulse only while the disable bit is low
  task automatic t_reseed;
    wr(fw(32'h0));
    s0 = reseed_n;
    wr(32'h0000_1230);
    check(reseed_n - s0, 1);
    wr(fw(32'h0000_4000));
    s0 = reseed_n;
    wr(32'h0000_1230);
    check(reseed_n - s0, 0);
  endtask

  // Sync spacing is count times modulus events
  task automatic t_resync;
    wr(mr(1'b0, 12'h003));
    s0 = sync_n;
    wr(rs(2'h2, 12'h002));
    events(26, 8'h01);
    check(gap, 6);
    check(sync_n - s0, 4);
    wr(rs(2'h0, 12'h002));
    s0 = sync_n;
    events(14, 8'h01);
    check(sync_n - s0, 0);
  endtask

  // Cells ramp, saturate, drain singly, clear on disable
  task automatic t_slip;
    wr(mr(1'b1, 12'h003));
    pulse_in(i_slip_imminent, 3);
    check(o_extra_cells, 3'h3);
    pulse_in(i_slip_imminent, 6);
    check(o_extra_cells, 3'h7);
    prev_cells = o_extra_cells;
    @(negedge i_clk);
    i_overshoot = 1'b1;
    @(negedge i_clk);
    i_overshoot = 1'b0;
    repeat (12) begin
      @(negedge i_clk);
      check(3'(prev_cells - o_extra_cells) <= 3'h1, 1'b1);
      prev_cells = o_extra_cells;
    end
    check(o_extra_cells, 3'h0);
    pulse_in(i_slip_imminent, 2);
    wr(fw(32'h0000_0020));
    check(o_extra_cells, 3'h0);
    wr(fw(32'h0));
    pulse_in(i_slip_imminent, 2);
    wr(mr(1'b0, 12'h003));
    check(o_extra_cells, 3'h0);
  endtask

  // Halved comparison clock toggles once per period
  task automatic t_cmpclk;
    // Halving off: clock follows each pulse up and down
    s0 = tog_n;
    pulse_in(i_div_ref_pulse, 2);
    check(tog_n - s0, 4);
    i_ref_div2_en = 1'b1;
    s0 = tog_n;
    pulse_in(i_div_ref_pulse, 4);
    check(tog_n - s0, 4);
  endtask

  initial begin
    repeat (10) @(negedge i_clk);
    i_rstn = 1'b1;
    @(negedge i_clk);
    check({o_cp_tristate, o_power_down, o_lock, o_extra_cells, o_fractional_modulus}, 32'h0);
    // Power-up programming order
    wr(rs(2'h0, 12'h001));
    wr(fw(32'h0000_0040));
    wr(mr(1'b0, 12'h003));
    wr(32'h0000_0011);
    wr(32'h0000_0080);
    t_lock(1'b0);
    t_lock(1'b1);
    t_power();
    t_reseed();
    t_resync();
    t_slip();
    t_cmpclk();
    wrap_up();
  end

  // Watchdog: run needs about 3600 cycles, allow 20000
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule // testbench
